// [design/audio_arith_regs.svh]
// Notes on behaviour
// - Samples are 32-bit two's complement, sign on top, 31 magnitude bits.
// - Gain multiplies a signed 32-bit sample by a signed 28-bit coefficient.
// - A stand-alone gain product of 60 bits is truncated to 32 bits.
// - Offset adds a signed 32-bit data word to a signed 32-bit sample.
// - Positive overflow of an offset addition clamps to the largest value.
// - Negative overflow of an offset addition clamps to the smallest value.
// - Word keeps four guard bits on top and four noise bits below.
// - Incoming audio sits with its msb just below the guard bits.
// - Bit 31 is the sign; all incoming audio is signed.
// - Data words are 9.23; general multiplies pair them with 5.23 values.
// - Summed products feed a 60-bit accumulator at full precision.
// - The accumulator never saturates; intermediate overflow wraps.
// - Biquads run direct form I with one accumulation node each.
// - Memory is a dual-port data RAM, coefficient RAM and program ROM.
// - Only the coefficient RAM is reachable by the host.
// - Program is fixed in ROM; behaviour set only by coefficients.
// - Gain coefficients are 28-bit 5.23 values.
// - Coefficients are two's complement; top bit set means negative.
// - The 28-bit coefficient is right-aligned, top four bits dropped.
`ifndef AUDIO_ARITH_REGS_SVH
`define AUDIO_ARITH_REGS_SVH

`define DATA_W         32
`define COEF_W         28
`define PROD_W         60
`define FRAC_BITS      23
`define GUARD_BITS     4
`define NOISE_BITS     4
`define AUDIO_IN_W     24
`define SAT_POS        32'h7fffffff
`define SAT_NEG        32'h80000000
`define COEF_BYTES     4
`define COEF_DEPTH     64
`define DATA_DEPTH     64
`define PROG_DEPTH     32

`endif

// [design/audio_arith_pkg.sv]
package audio_arith_pkg;

  // Operations of one program step
  typedef enum logic [2:0] {
    OP_NOP   = 3'h0,
    OP_LOAD  = 3'h1, // Audio input into data RAM
    OP_GAIN  = 3'h2, // Multiply, truncate, store
    OP_OFFS  = 3'h3, // Saturating add, store
    OP_MACC  = 3'h4, // Clear acc, then multiply-accumulate
    OP_MACA  = 3'h5, // Multiply-accumulate
    OP_STACC = 3'h6, // Store truncated accumulator
    OP_OUT   = 3'h7  // Present data word at output
  } op_t;

  // Sequencer states, Gray along idle-fetch-exec-write
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b11,
    ST_WRITE = 2'b10
  } seq_state_t;

  typedef struct packed {
    op_t        op;
    logic [5:0] daddr_a;
    logic [5:0] daddr_b;
    logic [5:0] caddr;
    logic       last;
  } instr_t;

endpackage

// [design/coef_byte_loader.sv]
`timescale 1ns/10ps
`include "audio_arith_regs.svh"
// Assembles four host bytes into one coefficient word
module coef_byte_loader #(
  parameter int ADDR_W = 6
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  input  wire logic              word_start,
  input  wire logic [ADDR_W-1:0] word_addr,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [`COEF_W-1:0]     wr_data
);

  logic [23:0]       shift;
  logic [1:0]        count;
  logic [ADDR_W-1:0] addr_hold;
  // A new start in the same cycle wins over a fourth byte
  wire               last_byte = byte_valid && (count == 2'h3) &&
                                 !word_start;

  ////////////////////////////////////////////////////////////////////////
  // Bytes arrive msb first; the word is written only on the fourth
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count <= 2'h0;
      shift <= 24'h000000;
      addr_hold <= '0;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_en <= last_byte;
      if (word_start) begin
        count <= 2'h0;
        addr_hold <= word_addr;
      end else if (byte_valid) begin
        count <= count + 2'h1;
        shift <= {shift[15:0], byte_data};
      end
      if (last_byte) begin
        wr_addr <= addr_hold;
        // Top nibble is unused and dropped
        wr_data <= {shift[19:0], byte_data};
      end
    end
  end

endmodule

// [design/mac_unit.sv]
`timescale 1ns/10ps
`include "audio_arith_regs.svh"
// Arithmetic core: multiply, truncate, saturating add, wrapping accumulate
module mac_unit (
  input  wire logic                clk_sys,
  input  wire logic                srst,
  input  wire logic [`DATA_W-1:0]  data_a,
  input  wire logic [`DATA_W-1:0]  data_b,
  input  wire logic [`COEF_W-1:0]  coef,
  input  wire logic                acc_clear,
  input  wire logic                acc_add,
  output logic [`DATA_W-1:0]       gain_out,
  output logic [`DATA_W-1:0]       offs_out,
  output logic [`DATA_W-1:0]       acc_out,
  output logic [`PROD_W-1:0]       acc
);

  // Keep 9.23 alignment: drop 23 low bits and the excess high bits
  function automatic logic [`DATA_W-1:0] trunc_prod(
    input logic [`PROD_W-1:0] p
  );
    trunc_prod = p[`FRAC_BITS +: `DATA_W];
  endfunction

  wire signed [`DATA_W-1:0] sa = data_a;
  wire signed [`DATA_W-1:0] sb = data_b;
  wire signed [`COEF_W-1:0] sc = coef;
  wire signed [`PROD_W-1:0] prod = sa * sc;
  wire signed [`DATA_W:0]   sum = {sa[`DATA_W-1], sa} + {sb[`DATA_W-1], sb};
  wire                      ovf_pos = !sum[`DATA_W] && sum[`DATA_W-1];
  wire                      ovf_neg = sum[`DATA_W] && !sum[`DATA_W-1];
  wire [`DATA_W-1:0]        sat_sum = ovf_pos ? `SAT_POS :
                                      ovf_neg ? `SAT_NEG :
                                      sum[`DATA_W-1:0];
  // Wrap is deliberate: later terms may bring the sum back
  wire [`PROD_W-1:0]        acc_base = acc_clear ? '0 : acc;
  wire [`PROD_W-1:0]        next_acc = acc_base + prod;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc <= '0;
      gain_out <= '0;
      offs_out <= '0;
      acc_out <= '0;
    end else begin
      if (acc_add)
        acc <= next_acc;
      gain_out <= trunc_prod(prod);
      offs_out <= sat_sum;
      acc_out <= trunc_prod(acc);
    end
  end

endmodule

// [design/audio_arith_processor.sv]
`timescale 1ns/10ps
`include "audio_arith_regs.svh"
// Fixed-program audio arithmetic processor
module audio_arith_processor #(
  parameter int COEF_DEPTH = `COEF_DEPTH,
  parameter int DATA_DEPTH = `DATA_DEPTH,
  parameter int PROG_DEPTH = `PROG_DEPTH
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire logic                   sample_valid,
  input  wire logic [`AUDIO_IN_W-1:0] sample_in,
  output logic                        busy,
  output logic                        out_valid,
  output logic [`DATA_W-1:0]          out_data,
  input  wire logic                   host_byte_valid,
  input  wire logic [7:0]             host_byte,
  input  wire logic                   host_word_start,
  input  wire logic [5:0]             host_addr,
  input  wire logic                   host_rd,
  output logic [`COEF_W-1:0]          host_rd_data
);

  // Addresses are six bits wide and the program needs ten steps
  if (COEF_DEPTH != 64 || DATA_DEPTH != 64 ||
      PROG_DEPTH < 10 || PROG_DEPTH > 32) begin : g_bad_depth
    $error("Unsupported memory depth");
  end

  // Program ROM: one direct form I biquad, then a gain and an offset
  function automatic audio_arith_pkg::instr_t rom(input logic [4:0] pc);
    case (pc)
      5'h00: rom = '{audio_arith_pkg::OP_LOAD, 6'h00, 6'h00, 6'h00, 1'b0};
      5'h01: rom = '{audio_arith_pkg::OP_MACC, 6'h00, 6'h00, 6'h00, 1'b0};
      5'h02: rom = '{audio_arith_pkg::OP_MACA, 6'h01, 6'h00, 6'h01, 1'b0};
      5'h03: rom = '{audio_arith_pkg::OP_MACA, 6'h02, 6'h00, 6'h02, 1'b0};
      5'h04: rom = '{audio_arith_pkg::OP_MACA, 6'h03, 6'h00, 6'h03, 1'b0};
      5'h05: rom = '{audio_arith_pkg::OP_MACA, 6'h04, 6'h00, 6'h04, 1'b0};
      5'h06: rom = '{audio_arith_pkg::OP_STACC, 6'h05, 6'h00, 6'h00, 1'b0};
      5'h07: rom = '{audio_arith_pkg::OP_GAIN, 6'h05, 6'h00, 6'h05, 1'b0};
      5'h08: rom = '{audio_arith_pkg::OP_OFFS, 6'h05, 6'h05, 6'h00, 1'b0};
      5'h09: rom = '{audio_arith_pkg::OP_OUT, 6'h05, 6'h00, 6'h00, 1'b1};
      default: rom = '{audio_arith_pkg::OP_NOP, 6'h00, 6'h00, 6'h00, 1'b1};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Memories: data RAM (two read ports), coefficient RAM
  logic [`DATA_W-1:0] data_ram [DATA_DEPTH];
  logic [`COEF_W-1:0] coef_ram [COEF_DEPTH];

  audio_arith_pkg::seq_state_t state;
  audio_arith_pkg::seq_state_t next_state;
  audio_arith_pkg::instr_t     ir;
  audio_arith_pkg::instr_t     rom_word;
  logic [4:0]                  pc;
  logic [`DATA_W-1:0]          rd_a;
  logic [`DATA_W-1:0]          rd_b;
  logic [`COEF_W-1:0]          rd_c;
  logic [`DATA_W-1:0]          in_word;
  logic                        cw_en;
  logic [5:0]                  cw_addr;
  logic [`COEF_W-1:0]          cw_data;
  logic [`DATA_W-1:0]          gain_out;
  logic [`DATA_W-1:0]          offs_out;
  logic [`DATA_W-1:0]          acc_out;
  logic [`DATA_W-1:0]          wr_val;

  // Audio msb abuts the guard bits; noise bits start at zero
  wire [`DATA_W-1:0] placed = {{`GUARD_BITS{sample_in[`AUDIO_IN_W-1]}},
                               sample_in, {`NOISE_BITS{1'b0}}};

  // Step addressed by the program counter, used by fetch and operand read
  assign rom_word = rom(pc);

  wire is_exec  = (state == audio_arith_pkg::ST_EXEC);
  wire is_write = (state == audio_arith_pkg::ST_WRITE);
  wire op_macc  = (ir.op == audio_arith_pkg::OP_MACC);
  wire op_mac   = op_macc || (ir.op == audio_arith_pkg::OP_MACA);
  wire op_store = (ir.op == audio_arith_pkg::OP_LOAD) ||
                  (ir.op == audio_arith_pkg::OP_GAIN) ||
                  (ir.op == audio_arith_pkg::OP_OFFS) ||
                  (ir.op == audio_arith_pkg::OP_STACC);

  // Result selected per operation; the biquad sum leaves via one node
  assign wr_val = (ir.op == audio_arith_pkg::OP_LOAD)  ? in_word :
                  (ir.op == audio_arith_pkg::OP_GAIN)  ? gain_out :
                  (ir.op == audio_arith_pkg::OP_OFFS)  ? offs_out :
                  acc_out;

  // Coefficient bytes assembled before any write reaches the RAM
  coef_byte_loader #(.ADDR_W(6)) u_loader (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .byte_valid (host_byte_valid),
    .byte_data  (host_byte),
    .word_start (host_word_start),
    .word_addr  (host_addr),
    .wr_en      (cw_en),
    .wr_addr    (cw_addr),
    .wr_data    (cw_data)
  );

  mac_unit u_mac (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .data_a    (rd_a),
    .data_b    (rd_b),
    .coef      (rd_c),
    .acc_clear (op_macc),
    .acc_add   (is_exec && op_mac),
    .gain_out  (gain_out),
    .offs_out  (offs_out),
    .acc_out   (acc_out),
    .acc       ()
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: a sample starts one pass through the fixed program
  always_comb begin
    next_state = state;
    case (state)
      audio_arith_pkg::ST_IDLE:
        if (sample_valid)
          next_state = audio_arith_pkg::ST_FETCH;
      audio_arith_pkg::ST_FETCH: next_state = audio_arith_pkg::ST_EXEC;
      audio_arith_pkg::ST_EXEC:  next_state = audio_arith_pkg::ST_WRITE;
      audio_arith_pkg::ST_WRITE:
        next_state = ir.last ? audio_arith_pkg::ST_IDLE
                             : audio_arith_pkg::ST_FETCH;
      default: next_state = audio_arith_pkg::ST_IDLE;
    endcase
  end

  // Program counter and instruction register; ROM is never written
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= audio_arith_pkg::ST_IDLE;
      pc <= 5'h00;
      ir <= '{audio_arith_pkg::OP_NOP, 6'h00, 6'h00, 6'h00, 1'b1};
      in_word <= '0;
    end else begin
      state <= next_state;
      if (state == audio_arith_pkg::ST_IDLE && sample_valid) begin
        pc <= 5'h00;
        in_word <= placed;
      end else if (state == audio_arith_pkg::ST_FETCH) begin
        ir <= rom_word;
        pc <= pc + 5'h01;
      end
    end
  end

  // Operand reads from both data ports and the coefficient RAM
  always_ff @(posedge clk_sys) begin
    if (state == audio_arith_pkg::ST_FETCH) begin
      rd_a <= data_ram[rom_word.daddr_a];
      rd_b <= data_ram[rom_word.daddr_b];
      rd_c <= coef_ram[rom_word.caddr];
    end
  end

  // Data RAM written only by the program, never by the host; cleared at
  // reset so that the delay taps start at zero instead of unknown
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < DATA_DEPTH; i++)
        data_ram[i] <= '0;
    end else if (is_write && op_store) begin
      data_ram[ir.daddr_a] <= wr_val;
    end
  end

  // Host side: complete words in, words out on request
  always_ff @(posedge clk_sys) begin
    if (cw_en)
      coef_ram[cw_addr] <= cw_data;
    if (srst)
      host_rd_data <= '0;
    else if (host_rd)
      host_rd_data <= coef_ram[host_addr];
  end

  // Output word and its strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= is_write && (ir.op == audio_arith_pkg::OP_OUT);
      if (is_write && ir.op == audio_arith_pkg::OP_OUT)
        out_data <= rd_a;
    end
  end

  assign busy = (state != audio_arith_pkg::ST_IDLE);

endmodule

// [sim/audio_arith_processor_chk.sv]
`timescale 1ns/10ps
`include "audio_arith_regs.svh"
////////////////////////////////////////////////////////////////////////////
// Port-level checks of the sample pass and the host read path
module audio_arith_chk (
  input wire logic                   clk_sys,
  input wire logic                   srst,
  input wire logic                   sample_valid,
  input wire logic [`AUDIO_IN_W-1:0] sample_in,
  input wire logic                   busy,
  input wire logic                   out_valid,
  input wire logic [`DATA_W-1:0]     out_data,
  input wire logic                   host_byte_valid,
  input wire logic [7:0]             host_byte,
  input wire logic                   host_word_start,
  input wire logic [5:0]             host_addr,
  input wire logic                   host_rd,
  input wire logic [`COEF_W-1:0]     host_rd_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // A sample is only taken while the sequencer is idle
  wire take = sample_valid && !busy;

  // Ten steps of fetch, execute and write; strobe seen one edge later
  AST_PASS_LEN: assert property (take |-> ##31 out_valid)
    else $error("result missing after sample take");
  AST_BUSY_ON: assert property (take |=> busy [*8])
    else $error("busy not held after sample take");
  AST_PULSE: assert property (out_valid |=> !out_valid)
    else $error("result strobe longer than one cycle");
  AST_NO_SPUR: assert property (!busy && !$past(busy) |-> !out_valid)
    else $error("result strobe without a running pass");
  AST_OUT_HOLD: assert property (!out_valid |-> $stable(out_data))
    else $error("result word changed without strobe");
  AST_END_IDLE: assert property (out_valid |-> ##[0:1] !busy)
    else $error("busy still high after result");
  AST_RD_ONLY: assert property (!$stable(host_rd_data) |-> $past(host_rd))
    else $error("read data changed without a read");
  AST_START: assert property ($rose(busy) |-> $past(sample_valid))
    else $error("pass started without a sample");
  cover property (take);
endmodule

bind audio_arith_processor audio_arith_chk u_chk (
  .clk_sys(clk_sys), .srst(srst), .sample_valid(sample_valid),
  .sample_in(sample_in), .busy(busy), .out_valid(out_valid),
  .out_data(out_data), .host_byte_valid(host_byte_valid),
  .host_byte(host_byte), .host_word_start(host_word_start),
  .host_addr(host_addr), .host_rd(host_rd), .host_rd_data(host_rd_data)
);

// [sim/tb_fixed_point_audio_mac_datapath.sv]
`timescale 1ns/10ps
`include "audio_arith_regs.svh"
////////////////////////////////////////////////////////////////////////////
module tb_fixed_point_audio_mac_datapath;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        sample_valid = 1'b0;
  logic [23:0] sample_in = 24'h000000;
  logic        busy, out_valid;
  logic [31:0] out_data;
  logic        host_byte_valid = 1'b0;
  logic [7:0]  host_byte = 8'h00;
  logic        host_word_start = 1'b0;
  logic [5:0]  host_addr = 6'h00;
  logic        host_rd = 1'b0;
  logic [27:0] host_rd_data;
  int          err_count = 0;
  int          total_checks = 0;
  // Gain 8.0 then 2.0 so that the final doubling can clip
  localparam logic [27:0] C0 = 28'h4000000;
  localparam logic [27:0] C5 = 28'h1000000;
  // Ten program steps of fetch, execute and write
  localparam int          PASS_LEN = 30;
  logic [27:0] c5_now = C5;

  always #12.5 clk_sys = ~clk_sys;

  audio_arith_processor DUT (
    .clk_sys(clk_sys), .srst(srst), .sample_valid(sample_valid),
    .sample_in(sample_in), .busy(busy), .out_valid(out_valid),
    .out_data(out_data), .host_byte_valid(host_byte_valid),
    .host_byte(host_byte), .host_word_start(host_word_start),
    .host_addr(host_addr), .host_rd(host_rd), .host_rd_data(host_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers; all driving happens at the falling edge
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Word start, then nb bytes msb first with no gaps
  task automatic wr_word(logic [5:0] a, logic [31:0] w, int nb);
    @(negedge clk_sys);
    host_word_start = 1'b1;
    host_addr = a;
    @(negedge clk_sys);
    host_word_start = 1'b0;
    for (int i = 0; i < nb; i++) begin
      host_byte_valid = 1'b1;
      host_byte = w[31-8*i -: 8];
      @(negedge clk_sys);
    end
    host_byte_valid = 1'b0;
  endtask

  task automatic rd_chk(logic [5:0] a, logic [27:0] exp);
    @(negedge clk_sys);
    host_rd = 1'b1;
    host_addr = a;
    @(negedge clk_sys);
    host_rd = 1'b0;
    chk({4'h0, host_rd_data}, {4'h0, exp});
  endtask

  // Reference: place, two truncated gains, saturating doubling
  function automatic logic [31:0] model(logic [23:0] s);
    logic signed [31:0] d;
    logic signed [59:0] p;
    logic signed [32:0] sm;
    d = {{4{s[23]}}, s, 4'h0};
    p = d * $signed(C0);
    d = p[54:23];
    p = d * $signed(c5_now);
    d = p[54:23];
    sm = {d[31], d} + {d[31], d};
    if (sm > 33'sh07fffffff) return 32'h7fffffff;
    if (sm < -33'sh080000000) return 32'h80000000;
    return sm[31:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_coef_rw();
    wr_word(6'd10, 32'hf0800000, 4);
    rd_chk(6'd10, 28'h0800000);
    wr_word(6'd12, 32'h0ffffffe, 4);
    rd_chk(6'd12, 28'hffffffe);
  endtask

  // A word cut short by a new start must leave the old value
  task automatic t_partial();
    wr_word(6'd10, 32'h01234567, 4);
    wr_word(6'd10, 32'h0abcdef0, 3);
    wr_word(6'd11, 32'h07654321, 4);
    rd_chk(6'd10, 28'h1234567);
    rd_chk(6'd11, 28'h7654321);
  endtask

  task automatic t_pass(logic [23:0] s);
    int n;
    @(negedge clk_sys);
    sample_valid = 1'b1;
    sample_in = s;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    n = 0;
    while (out_valid !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n, PASS_LEN);
    chk(out_data, model(s));
  endtask

  // A second sample while busy is dropped silently
  task automatic t_refuse();
    int extra;
    t_pass(24'h000010);
    extra = 0;
    wr_word(6'd20, 32'h0, 0);
    @(negedge clk_sys);
    sample_valid = 1'b1;
    @(negedge clk_sys);
    @(negedge clk_sys);
    sample_valid = 1'b0;
    for (int i = 0; i < 90; i++) begin
      @(negedge clk_sys);
      if (out_valid === 1'b1) extra++;
    end
    chk(extra, 1);
  endtask

  // Finest negative gain: the dropped fraction floors toward minus one
  task automatic t_fine();
    c5_now = 28'hfffffff;
    wr_word(6'd5, {4'h0, c5_now}, 4);
    rd_chk(6'd5, 28'hfffffff);
    t_pass(24'h000010);
    chk(out_data, 32'hfffffffe);
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the roughly 420 cycles the run needs
  initial begin
    #(25 * 5000);
    err_count++;
    results();
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    srst = 1'b0;
    t_coef_rw();
    t_partial();
    // Program coefficients: c0 gain, c1..c4 zero, c5 gain
    wr_word(6'd0, {4'h0, C0}, 4);
    for (int i = 1; i < 5; i++) wr_word(i[5:0], 32'h0, 4);
    wr_word(6'd5, {4'h0, C5}, 4);
    t_pass(24'h7fffff);
    t_pass(24'h800000);
    t_pass(24'h000010);
    t_pass(24'hfffff0);
    t_pass(24'h0c0001);
    t_refuse();
    t_fine();
    results();
  end
endmodule
